// ---- rtl/crc_pkg.sv ----
// Package: constants shared by the converter register and sequencing core
package crc_pkg;

    // ==========================================================
    // Register widths
    localparam int INSTR_W  = 8;
    localparam int RESULT_W = 24;
    localparam int CTRL_W   = 32;
    localparam int CAL_W    = 24;

    // ==========================================================
    // Instruction word fields
    localparam int INSTR_RW_BIT   = 7;
    localparam int INSTR_CNT_HI   = 6;
    localparam int INSTR_CNT_LO   = 5;
    localparam int INSTR_ADDR_HI  = 3;

    // ==========================================================
    // Register byte locations (most significant byte first)
    localparam logic [3:0] LOC_RESULT_B2 = 4'h0;
    localparam logic [3:0] LOC_RESULT_B0 = 4'h2;
    localparam logic [3:0] LOC_CTRL_B3   = 4'h4;
    localparam logic [3:0] LOC_CTRL_B0   = 4'h7;
    localparam logic [3:0] LOC_OFFS_B2   = 4'h8;
    localparam logic [3:0] LOC_OFFS_B0   = 4'hA;
    localparam logic [3:0] LOC_GAIN_B2   = 4'hC;
    localparam logic [3:0] LOC_GAIN_B0   = 4'hE;

    // ==========================================================
    // Control word fields
    localparam int CTRL_BIAS_BIT = 31;
    localparam int CTRL_REFO_BIT = 30;
    localparam int CTRL_DF_BIT   = 29;
    localparam int CTRL_BD_BIT   = 27;
    localparam int CTRL_MD_LO    = 21;
    localparam int CTRL_GAIN_LO  = 18;
    localparam int CTRL_CH_LO    = 16;
    localparam int CTRL_TMR_LO   = 13;
    localparam int CTRL_DR_LO    = 0;
    localparam int CTRL_DR_W     = 13;

    // ==========================================================
    // Values after reset
    localparam logic [31:0] CTRL_RESET   = 32'h4000_0016;
    localparam logic [23:0] RESULT_RESET = 24'h00_0000;
    localparam logic [23:0] OFFS_RESET   = 24'h00_0000;
    localparam logic [23:0] GAIN_UNITY   = 24'h40_0000;
    localparam int          GAIN_SHIFT   = 22;

    // ==========================================================
    // Sequencing
    localparam int          SYNC_STAGES    = 2;
    localparam logic [3:0]  SETTLE_SAMPLES = 4'h3;

    typedef enum logic [0:0] {
        SEQ_RESET   = 1'b0,
        SEQ_CONVERT = 1'b1
    } crc_seq_t;

endpackage

// ---- rtl/crc_corrector.sv ----
// Offset and gain correction of one raw conversion sample
`timescale 1ns/1ps
module crc_corrector (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          in_valid,
    input  wire logic [crc_pkg::RESULT_W-1:0]  raw,
    input  wire logic [crc_pkg::CAL_W-1:0]     offs,
    input  wire logic [crc_pkg::CAL_W-1:0]     gain,
    output logic                               out_valid,
    output logic [crc_pkg::RESULT_W-1:0]       corrected
);
    import crc_pkg::*;

    // ==========================================================
    // Arithmetic
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] scaled;
    logic [23:0]        corr_d;
    logic [23:0]        corr_q;
    logic               vld_q;

    always_comb begin
        diff   = $signed({raw[23], raw}) - $signed({offs[23], offs});
        prod   = 50'(diff) * $signed({26'h000_0000, gain});
        scaled = prod >>> GAIN_SHIFT;
        // Saturate rather than wrap so a bad calibration pins at full scale
        if (scaled > 50'sh7F_FFFF) begin
            corr_d = 24'h7F_FFFF;
        end else if (scaled < -50'sh80_0000) begin
            corr_d = 24'h80_0000;
        end else begin
            corr_d = scaled[23:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            corr_q <= RESULT_RESET;
            vld_q  <= 1'b0;
        end else begin
            corr_q <= corr_d;
            vld_q  <= in_valid;
        end
    end

    assign corrected = corr_q;
    assign out_valid = vld_q;

endmodule

// ---- rtl/crc_core.sv ----
// Register bank, serial link slave and sequencing controller
// Operation
// - The sequencing controller has only a reset state and a convert state, and in reset it restores defaults, settles and self-calibrates at the default 850Hz rate.
// - Once the reset work is done the controller moves by itself to the convert state and stays there.
// - There are exactly five registers: instruction word, conversion result, control word, offset correction and gain correction.
// - The control word is the only 32-bit register, the instruction word is 8 bits and the others are 24 bits.
// - The conversion result register holds the latest completed conversion; here a host write also replaces it until the next conversion completes.
// - Each raw result is corrected with the offset and gain registers before it is stored.
// - The correction registers take values from self-calibration and from host writes, and the last stored value is used.
// - Every serial transfer opens with an instruction word that decides what follows.
// - The instruction word register cannot be read back.
// - The control word holds all options and modes including gain, oversampling multiplier and data rate.
// - Result, control and both correction registers can be read and written by the host.
// - The internal reference is on by default and the host may switch it off via the control word.
// - The bias generator is off by default and drives only after the host enables it.
// - The instruction word carries direction, a length of one to four bytes and a start byte location.
// - A control byte takes effect on the falling serial clock edge of its last bit.
`timescale 1ns/1ps
module crc_core (
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    input  wire logic                          sdi,
    output logic                               sdo,
    output logic                               sdo_oe,
    input  wire logic                          mod_valid,
    input  wire logic [crc_pkg::RESULT_W-1:0]  mod_data,
    output logic                               cal_active,
    output logic                               data_ready,
    output logic                               ref_enable,
    output logic                               bias_enable,
    output logic [2:0]                         op_mode,
    output logic [2:0]                         pga_gain,
    output logic [1:0]                         channel,
    output logic [2:0]                         oversampling_rate_multiplier,
    output logic [crc_pkg::CTRL_DR_W-1:0]      decimation
);
    import crc_pkg::*;

    // ==========================================================
    // Pin synchronisers
    logic [SYNC_STAGES-1:0] sclk_sy_q, cs_sy_q, sdi_sy_q;
    logic                   sclk_old_q;
    logic                   rise, fall, cs_act;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_sy_q  <= '0;
            cs_sy_q    <= '1;
            sdi_sy_q   <= '0;
            sclk_old_q <= 1'b0;
        end else begin
            sclk_sy_q  <= {sclk_sy_q[0], sclk};
            cs_sy_q    <= {cs_sy_q[0], cs_n};
            sdi_sy_q   <= {sdi_sy_q[0], sdi};
            sclk_old_q <= sclk_sy_q[1];
        end
    end

    assign cs_act = !cs_sy_q[1];
    assign rise   = cs_act && sclk_sy_q[1] && !sclk_old_q;
    assign fall   = cs_act && !sclk_sy_q[1] && sclk_old_q;

    // ==========================================================
    // Registers
    logic [INSTR_W-1:0]  instruction_word_register_q;
    logic [RESULT_W-1:0] conversion_result_register_q, result_d;
    logic [CTRL_W-1:0]   control_word_register_q, ctrl_d;
    logic [CAL_W-1:0]    offset_correction_register_q, offs_d;
    logic [CAL_W-1:0]    gain_correction_register_q, gain_d;

    // Byte view for reads; unused locations answer zero
    function automatic logic [7:0] rd_byte(input logic [3:0] loc);
        logic [RESULT_W-1:0] res;
        res = conversion_result_register_q;
        res[RESULT_W-1] = res[RESULT_W-1] ^ control_word_register_q[CTRL_DF_BIT];
        unique case (loc)
            4'h0: rd_byte = res[23:16];
            4'h1: rd_byte = res[15:8];
            4'h2: rd_byte = res[7:0];
            4'h4: rd_byte = control_word_register_q[31:24];
            4'h5: rd_byte = control_word_register_q[23:16];
            4'h6: rd_byte = control_word_register_q[15:8];
            4'h7: rd_byte = control_word_register_q[7:0];
            4'h8: rd_byte = offset_correction_register_q[23:16];
            4'h9: rd_byte = offset_correction_register_q[15:8];
            4'hA: rd_byte = offset_correction_register_q[7:0];
            4'hC: rd_byte = gain_correction_register_q[23:16];
            4'hD: rd_byte = gain_correction_register_q[15:8];
            4'hE: rd_byte = gain_correction_register_q[7:0];
            default: rd_byte = 8'h00;
        endcase
    endfunction

    // ==========================================================
    // Serial link
    logic       ph_q, ph_d, rw_q, rw_d, done_q, done_d;
    logic [2:0] bit_q, bit_d;
    logic [1:0] left_q, left_d;
    logic [3:0] loc_q, loc_d, nxt;
    logic [7:0] shin_q, shin_d, shout_q, shout_d, rx;
    logic [7:0] instr_d;
    logic       wr_en;

    always_comb begin
        ph_d    = ph_q;
        rw_d    = rw_q;
        done_d  = done_q;
        bit_d   = bit_q;
        left_d  = left_q;
        loc_d   = loc_q;
        shin_d  = shin_q;
        shout_d = shout_q;
        instr_d = instruction_word_register_q;
        wr_en   = 1'b0;
        rx      = shin_q;
        nxt     = loc_q + 4'h1;
        // Descending order applies to reads only
        if (rw_q && control_word_register_q[CTRL_BD_BIT]) begin
            nxt = loc_q - 4'h1;
        end
        if (!cs_act) begin
            ph_d   = 1'b0;
            done_d = 1'b0;
            bit_d  = 3'h0;
        end else if (rise) begin
            shin_d = {shin_q[6:0], sdi_sy_q[1]};
        end else if (fall && !done_q) begin
            bit_d   = bit_q + 3'h1;
            shout_d = {shout_q[6:0], 1'b0};
            if (bit_q == 3'h7) begin
                if (!ph_q) begin
                    instr_d = rx;
                    ph_d    = 1'b1;
                    rw_d    = rx[INSTR_RW_BIT];
                    left_d  = rx[INSTR_CNT_HI:INSTR_CNT_LO];
                    loc_d   = rx[INSTR_ADDR_HI:0];
                    if (rx[INSTR_RW_BIT]) begin
                        shout_d = rd_byte(rx[INSTR_ADDR_HI:0]);
                    end
                end else begin
                    wr_en = !rw_q;
                    loc_d = nxt;
                    if (left_q == 2'h0) begin
                        done_d = 1'b1;
                    end else begin
                        left_d = left_q - 2'h1;
                        if (rw_q) begin
                            shout_d = rd_byte(nxt);
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_q    <= 1'b0;
            rw_q    <= 1'b0;
            done_q  <= 1'b0;
            bit_q   <= 3'h0;
            left_q  <= 2'h0;
            loc_q   <= 4'h0;
            shin_q  <= 8'h00;
            shout_q <= 8'h00;
            instruction_word_register_q <= 8'h00;
        end else begin
            ph_q    <= ph_d;
            rw_q    <= rw_d;
            done_q  <= done_d;
            bit_q   <= bit_d;
            left_q  <= left_d;
            loc_q   <= loc_d;
            shin_q  <= shin_d;
            shout_q <= shout_d;
            instruction_word_register_q <= instr_d;
        end
    end

    // Instruction word never reaches the read path
    assign sdo    = shout_q[7];
    assign sdo_oe = cs_act && ph_q && rw_q && !done_q;

    // ==========================================================
    // Sequencing controller
    crc_seq_t   seq_q, seq_d;
    logic [3:0] cnt_q, cnt_d;
    logic       corr_vld;
    logic [RESULT_W-1:0] corr_data;

    always_comb begin
        seq_d = seq_q;
        cnt_d = cnt_q;
        unique case (seq_q)
            SEQ_RESET: begin
                if (mod_valid) begin
                    if (cnt_q == SETTLE_SAMPLES) begin
                        seq_d = SEQ_CONVERT;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            SEQ_CONVERT: begin
                seq_d = SEQ_CONVERT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_q <= SEQ_RESET;
            cnt_q <= 4'h0;
        end else begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
        end
    end

    assign cal_active = (seq_q == SEQ_RESET);

    crc_corrector u_corr (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (mod_valid && seq_q == SEQ_CONVERT),
        .raw       (mod_data),
        .offs      (offset_correction_register_q),
        .gain      (gain_correction_register_q),
        .out_valid (corr_vld),
        .corrected (corr_data)
    );

    // ==========================================================
    // Register update
    always_comb begin
        result_d = conversion_result_register_q;
        ctrl_d   = control_word_register_q;
        offs_d   = offset_correction_register_q;
        gain_d   = gain_correction_register_q;
        if (wr_en) begin
            unique case (loc_q)
                4'h0: result_d[23:16] = rx;
                4'h1: result_d[15:8]  = rx;
                4'h2: result_d[7:0]   = rx;
                4'h4: ctrl_d[31:24]   = rx;
                4'h5: ctrl_d[23:16]   = rx;
                4'h6: ctrl_d[15:8]    = rx;
                4'h7: ctrl_d[7:0]     = rx;
                4'h8: offs_d[23:16]   = rx;
                4'h9: offs_d[15:8]    = rx;
                4'hA: offs_d[7:0]     = rx;
                4'hC: gain_d[23:16]   = rx;
                4'hD: gain_d[15:8]    = rx;
                4'hE: gain_d[7:0]     = rx;
                default: ;
            endcase
        end
        // Self-calibration: last settling sample is taken as zero input
        if (seq_q == SEQ_RESET && mod_valid && cnt_q == SETTLE_SAMPLES) begin
            offs_d = mod_data;
            gain_d = GAIN_UNITY;
        end
        // A finished conversion overwrites any host value
        if (corr_vld) begin
            result_d = corr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conversion_result_register_q <= RESULT_RESET;
            control_word_register_q      <= CTRL_RESET;
            offset_correction_register_q <= OFFS_RESET;
            gain_correction_register_q   <= GAIN_UNITY;
        end else begin
            conversion_result_register_q <= result_d;
            control_word_register_q      <= ctrl_d;
            offset_correction_register_q <= offs_d;
            gain_correction_register_q   <= gain_d;
        end
    end

    // ==========================================================
    // Control outputs
    logic rdy_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= corr_vld;
        end
    end

    assign data_ready  = rdy_q;
    assign ref_enable  = control_word_register_q[CTRL_REFO_BIT];
    assign bias_enable = control_word_register_q[CTRL_BIAS_BIT];
    assign op_mode     = control_word_register_q[CTRL_MD_LO+:3];
    assign pga_gain    = control_word_register_q[CTRL_GAIN_LO+:3];
    assign channel     = control_word_register_q[CTRL_CH_LO+:2];
    assign oversampling_rate_multiplier =
        control_word_register_q[CTRL_TMR_LO+:3];
    // Calibration always runs at the default rate
    assign decimation  = cal_active ? CTRL_RESET[CTRL_DR_W-1:0]
                       : control_word_register_q[CTRL_DR_LO+:CTRL_DR_W];

endmodule

// ---- test/crc_core_chk.sv ----
// Checker: port-level properties of the converter core
`timescale 1ns/1ps
module crc_core_chk (
    input wire logic                         clk,
    input wire logic                         arst_n,
    input wire logic                         sclk,
    input wire logic                         cs_n,
    input wire logic                         sdi,
    input wire logic                         sdo,
    input wire logic                         sdo_oe,
    input wire logic                         mod_valid,
    input wire logic [crc_pkg::RESULT_W-1:0] mod_data,
    input wire logic                         cal_active,
    input wire logic                         data_ready,
    input wire logic                         ref_enable,
    input wire logic                         bias_enable,
    input wire logic [2:0]                   op_mode,
    input wire logic [2:0]                   pga_gain,
    input wire logic [1:0]                   channel,
    input wire logic [2:0]                   oversampling_rate_multiplier,
    input wire logic [crc_pkg::CTRL_DR_W-1:0] decimation
);
    import crc_pkg::*;
    // ==========================================================
    // Helper logic
    // Age since the raw serial clock last fell, saturating at 15
    logic        sclk_q;
    logic        sclk_d;
    logic [3:0]  fall_age_q;
    logic [3:0]  fall_age_d;
    logic [12:0] ctrl_vec;
    assign ctrl_vec = {bias_enable, ref_enable, op_mode, pga_gain, channel,
                       oversampling_rate_multiplier};
    always_comb begin
        sclk_d = sclk;
        fall_age_d = fall_age_q;
        if (sclk_q && !sclk) begin
            fall_age_d = 4'h0;
        end else if (fall_age_q != 4'hF) begin
            fall_age_d = fall_age_q + 4'h1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b0;
            fall_age_q <= 4'hF;
        end else begin
            sclk_q <= sclk_d;
            fall_age_q <= fall_age_d;
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_sample;
        mod_valid && !cal_active;
    endsequence
    sequence s_idle;
        cs_n [*4];
    endsequence
    conv_answer_a: assert property (
        s_sample |-> ##2 data_ready) else $error("result strobe missing");
    dready_cause_a: assert property (
        data_ready |-> $past(mod_valid, 2) && !$past(cal_active, 2))
        else $error("result strobe without a converted sample");
    cal_hold_a: assert property (
        !cal_active |=> !cal_active) else $error("left convert state");
    cal_rate_a: assert property (
        cal_active |-> decimation == 13'h0016)
        else $error("calibration rate wrong");
    idle_no_drive_a: assert property (
        s_idle |-> !sdo_oe) else $error("data out driven while idle");
    drive_needs_cs_a: assert property (
        sdo_oe |-> !$past(cs_n, 4) && !$past(cs_n, 40))
        else $error("data out driven before an instruction");
    ctrl_quiet_a: assert property (
        s_idle |-> $stable(ctrl_vec)) else $error("control moved while idle");
    ctrl_on_fall_a: assert property (
        !$stable(ctrl_vec) |-> fall_age_q <= 4'h8)
        else $error("control changed away from a falling clock");
    sdo_on_fall_a: assert property (
        sdo_oe && $past(sdo_oe) && !$stable(sdo) |-> fall_age_q <= 4'h8)
        else $error("data out changed away from a falling clock");
endmodule

bind crc_core crc_core_chk crc_core_chk_inst (.clk(clk), .arst_n(arst_n),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .mod_valid(mod_valid), .mod_data(mod_data), .cal_active(cal_active),
    .data_ready(data_ready), .ref_enable(ref_enable),
    .bias_enable(bias_enable), .op_mode(op_mode), .pga_gain(pga_gain),
    .channel(channel),
    .oversampling_rate_multiplier(oversampling_rate_multiplier),
    .decimation(decimation));

// ---- test/crc_host_model.sv ----
// Host model: drives framed serial transfers at an 8-clock bit period
`timescale 1ns/1ps
module crc_host_model (
    input wire logic clk,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic     sclk,
    output logic     cs_n,
    output logic     sdi
);
    // ==========================================================
    // Transfer
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Serial clock stands low between frames; sdi toggles when unused
    task automatic xfer(input logic [7:0] ins, input logic [31:0] wd,
                        output logic [31:0] rd);
        int nb;
        int i;
        logic b;
        nb = int'(ins[6:5]) + 1;
        rd = 32'h0000_0000;
        @(posedge clk);
        cs_n <= 1'b0;
        tick(4);
        for (i = 0; i < 8 + 8 * nb; i++) begin
            if (i < 8) begin
                b = ins[7 - i];
            end else if (!ins[7]) begin
                b = wd[8 * nb - 1 - (i - 8)];
            end else begin
                b = ~sdi;
            end
            sdi <= b;
            tick(4);
            sclk <= 1'b1;
            tick(2);
            // Released data line reads inverted, so a late enable shows
            if (i >= 8) begin
                rd = {rd[30:0], sdo_oe ? sdo : ~sdo};
            end
            tick(2);
            sclk <= 1'b0;
        end
        tick(4);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        tick(8);
    endtask
endmodule

// ---- test/tb_top.sv ----
// Testbench: random and corner traffic through the converter core
`timescale 1ns/1ps
module tb_top;
    import crc_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n, mod_valid, sclk, cs_n, sdi, sdo, sdo_oe;
    logic        cal_active, data_ready, ref_enable, bias_enable;
    logic [23:0] mod_data, off, gn, raw;
    logic [2:0]  op_mode, pga_gain, osr;
    logic [1:0]  channel;
    logic [12:0] decimation;
    logic [31:0] rng, v, c;
    logic [3:0]  holes [3] = '{4'h3, 4'hB, 4'hF};
    int          fail_count, checks, n, k;

    always #12.5 clk = ~clk;

    crc_core crc_core_inst (.clk(clk), .arst_n(arst_n), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .mod_valid(mod_valid), .mod_data(mod_data), .cal_active(cal_active),
        .data_ready(data_ready), .ref_enable(ref_enable),
        .bias_enable(bias_enable), .op_mode(op_mode), .pga_gain(pga_gain),
        .channel(channel), .oversampling_rate_multiplier(osr),
        .decimation(decimation));
    crc_host_model crc_host_model_inst (.clk(clk), .sdo(sdo),
        .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // Corrected and saturated sample, as the result register should hold
    function automatic logic [23:0] exp_conv(input logic [23:0] r,
        input logic [23:0] o, input logic [23:0] g);
        longint d;
        d = longint'($signed(r)) - longint'($signed(o));
        d = (d * longint'(g)) >>> 22;
        if (d > longint'(24'sh7F_FFFF)) d = longint'(24'sh7F_FFFF);
        if (d < longint'(24'sh80_0000)) d = longint'(24'sh80_0000);
        return d[23:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic rd(input logic [3:0] loc, input int nb,
                      output logic [31:0] r);
        crc_host_model_inst.xfer({1'b1, 2'(nb - 1), 1'b0, loc}, 32'h0, r);
    endtask
    task automatic wr(input logic [3:0] loc, input int nb,
                      input logic [31:0] w);
        logic [31:0] r;
        crc_host_model_inst.xfer({1'b0, 2'(nb - 1), 1'b0, loc}, w, r);
    endtask
    // One or two back-to-back samples; counts result strobes afterwards
    task automatic conv(input logic [23:0] a, input logic [23:0] b,
                        input bit two, output int seen);
        seen = 0;
        @(posedge clk);
        mod_valid <= 1'b1;
        mod_data <= a;
        if (two) begin
            @(posedge clk);
            mod_data <= b;
        end
        @(posedge clk);
        mod_valid <= 1'b0;
        mod_data <= ~b;
        repeat (6) begin
            @(negedge clk);
            if (data_ready === 1'b1) seen++;
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        arst_n = 1'b0;
        mod_valid = 1'b0;
        mod_data = 24'h00_0000;
        rng = 32'h0000_D257;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk(32'(cal_active), 32'h0000_0001);
        chk(32'(decimation), 32'h0000_0016);
        chk(32'({bias_enable, ref_enable}), 32'h0000_0001);
        rd(4'h4, 4, v);
        chk(v, CTRL_RESET);
        rd(4'h8, 3, v);
        chk(v, 32'(OFFS_RESET));
        rd(4'hC, 3, v);
        chk(v, 32'(GAIN_UNITY));
        rd(4'h0, 3, v);
        chk(v, 32'(RESULT_RESET));
        foreach (holes[k]) begin
            rd(holes[k], 1, v);
            chk(v, 32'h0000_0000);
        end
        for (k = 0; k < 4; k++) begin
            raw = 24'(rnd());
            conv(raw, raw, 1'b0, n);
            chk(32'(n), 32'h0000_0000);
        end
        off = raw;
        gn = GAIN_UNITY;
        chk(32'(cal_active), 32'h0000_0000);
        rd(4'h8, 3, v);
        chk(v, 32'(off));
        for (k = 0; k < 12; k++) begin
            if (k == 4 || k == 8) begin
                off = 24'(rnd());
                gn = (k == 8) ? 24'h7F_FFFF : {2'b01, 22'(rnd())};
                wr(4'h8, 3, 32'(off));
                wr(4'hC, 3, 32'(gn));
                rd(4'hC, 3, v);
                chk(v, 32'(gn));
            end
            raw = (k == 9) ? 24'h7F_FFFF : (k == 10) ? 24'h80_0000 : 24'(rnd());
            c = rnd();
            conv(raw, c[23:0], c[0], n);
            chk(32'(n), 32'(c[0]) + 32'h0000_0001);
            rd(4'h0, 3, v);
            chk(v, 32'(exp_conv(c[0] ? c[23:0] : raw, off, gn)));
        end
        wr(4'h4, 1, 32'h0000_0080);
        chk(32'({bias_enable, ref_enable}), 32'h0000_0002);
        c = rnd();
        wr(4'h5, 3, c);
        chk(32'({op_mode, pga_gain, channel, osr, decimation}),
            32'(c[23:0]));
        rd(4'h4, 4, v);
        chk(v, {8'h80, c[23:0]});
        wr(4'h4, 1, 32'h0000_0040);
        chk(32'({bias_enable, ref_enable}), 32'h0000_0001);
        c = rnd();
        wr(4'h0, 3, c);
        rd(4'h0, 3, v);
        chk(v, 32'(c[23:0]));
        raw = 24'(rnd());
        conv(raw, raw, 1'b0, n);
        rd(4'h0, 3, v);
        chk(v, 32'(exp_conv(raw, off, gn)));
        // Offset binary and descending reads: MSB flips, bytes reverse
        wr(4'h4, 1, 32'h0000_0068);
        rd(4'h2, 3, v);
        c = 32'(exp_conv(raw, off, gn)) ^ 32'h0080_0000;
        chk(v, {8'h00, c[7:0], c[15:8], c[23:16]});
        // Writes still ascend while reads descend
        wr(4'h8, 2, 32'h0000_1234);
        rd(4'h9, 2, v);
        chk(v, 32'h0000_3412);
        tally_and_finish();
    end
endmodule
